/* hw/capture_pkg.sv */
// constants and carriers for the bus exception capture block
// assumes a 10 MHz ref_clk and a byte-addressed register port
package capture_pkg;

   localparam int REG_ADDR_W = 12;
   localparam int DATA_W = 32;

   // register byte offsets
   localparam logic [11:0] OFS_VME_ADDR_HI = 12'h260;
   localparam logic [11:0] OFS_VME_ADDR_LO = 12'h264;
   localparam logic [11:0] OFS_VME_ATTR = 12'h268;
   localparam logic [11:0] OFS_PCIX_ADDR_HI = 12'h270;
   localparam logic [11:0] OFS_PCIX_ADDR_LO = 12'h274;
   localparam logic [11:0] OFS_PCIX_ATTR_PHASE = 12'h278;
   localparam logic [11:0] OFS_PCIX_SPLIT_MSG = 12'h27c;
   localparam logic [11:0] OFS_PCIX_CAUSE = 12'h280;
   localparam logic [11:0] OFS_IRQ_STATUS = 12'h290;
   localparam logic [11:0] OFS_IRQ_MASK = 12'h294;

   // status, overflow and clear bit positions on both sides
   localparam int BIT_VALID = 31;
   localparam int BIT_OVF = 30;
   localparam int BIT_CLEAR = 29;

   localparam int VME_ATTR_W = 22;
   localparam int PCIX_CAUSE_W = 18;
   localparam int ADDR_HALF = 32;

   // interrupt status bits
   localparam int IRQ_W = 4;
   localparam int IRQ_VME_CAP = 0;
   localparam int IRQ_VME_OVF = 1;
   localparam int IRQ_PCIX_CAP = 2;
   localparam int IRQ_PCIX_OVF = 3;

   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   // vme attribute word, bits 21:0
   typedef struct packed {
      logic odd_beat_termination;
      logic two_edge_slave_stop;
      logic bus_error;
      logic lword;
      logic write;
      logic iack;
      logic ds1;
      logic ds0;
      logic [5:0] am;
      logic [7:0] xam;
   } vme_attr_t;

   // pcix cause word, bits 17:0
   typedef struct packed {
      logic split_completion_dropped;
      logic unexpected_split_seen;
      logic split_response_timeout_flag;
      logic split_error_message_flag;
      logic master_parity_reported;
      logic parity_error_detected;
      logic retry_limit_exceeded;
      logic got_master_abort;
      logic got_target_abort;
      logic delayed_txn_timeout;
      logic [3:0] byte_enable_attribute;
      logic [3:0] bus_command_capture;
   } pcix_cause_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [11:0] addr;
      logic [31:0] wdata;
   } reg_req_t;

   // all bus lines given asserted-high
   typedef struct packed {
      logic master_active;
      logic error_end;
      logic slave_stop;
      logic sst_mode;
      logic last_word_invalid;
      logic odd_beat;
      logic [63:0] addr;
      logic lword;
      logic write;
      logic iack;
      logic ds1;
      logic ds0;
      logic [5:0] am;
      logic [7:0] xam;
   } vme_event_t;

   typedef struct packed {
      logic error;
      logic [63:0] addr;
      logic [31:0] attr_phase;
      logic [31:0] split_msg;
      pcix_cause_t cause;
   } pcix_event_t;

   typedef struct packed {
      logic [31:0] vme_addr_hi;
      logic [30:0] vme_addr_lo;
      vme_attr_t vme_attr;
      logic vme_valid;
      logic vme_ovf;
      logic [31:0] pcix_addr_hi;
      logic [31:0] pcix_addr_lo;
      logic [31:0] pcix_attr_phase;
      logic [31:0] pcix_split;
      pcix_cause_t pcix_cause;
      logic pcix_valid;
      logic pcix_ovf;
      logic [31:0] rd_data;
   } capture_state_t;

   typedef struct packed {
      logic [3:0] status;
      logic [3:0] mask;
      logic irq;
   } irq_state_t;

endpackage : capture_pkg

/* hw/irq_status_unit.sv */
// sticky event status, mask and level interrupt for the capture block
// assumes set pulses and write strobes synchronous to ref_clk
`timescale 1ns/1ps
module irq_status_unit (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic ce,
   input wire logic [3:0] event_set,
   input wire logic wr_status,
   input wire logic wr_mask,
   input wire logic [3:0] wdata,
   output logic [3:0] status_reg,
   output logic [3:0] mask_reg,
   output logic irq_reg
);
   capture_pkg::irq_state_t st_reg;
   capture_pkg::irq_state_t st_next;

   always_comb begin
      st_next = st_reg;
      // write one clears, a new event in the same cycle wins
      if (wr_status) begin
         st_next.status = st_reg.status & ~wdata;
      end
      st_next.status = st_next.status | event_set;
      if (wr_mask) begin
         st_next.mask = wdata;
      end
      st_next.irq = |(st_next.status & st_next.mask);
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= '0;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   assign status_reg = st_reg.status;
   assign mask_reg = st_reg.mask;
   assign irq_reg = st_reg.irq;

endmodule : irq_status_unit

/* hw/bus_exception_capture.sv */
// capture of vme exception and pcix bus error diagnostics
// assumes event inputs synchronous to ref_clk, one cycle per event
`timescale 1ns/1ps

module bus_exception_capture (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic ce,
   input wire capture_pkg::reg_req_t bus_req,
   input wire capture_pkg::vme_event_t vme_in,
   input wire capture_pkg::pcix_event_t pcix_in,
   output logic [31:0] rd_data_reg,
   output logic irq_reg
);
   capture_pkg::capture_state_t st_reg;
   capture_pkg::capture_state_t st_next;

   logic vme_slv_2evme;
   logic vme_lwi;
   logic vme_exc;
   logic vme_clr;
   logic vme_fire;
   logic vme_ovf_evt;
   logic pcix_clr;
   logic pcix_fire;
   logic pcix_ovf_evt;
   logic wr_irq_status;
   logic wr_irq_mask;
   logic [3:0] irq_status;
   logic [3:0] irq_mask;
   logic [3:0] irq_events;

   // exception qualification
   assign vme_slv_2evme = vme_in.slave_stop & ~vme_in.sst_mode;
   assign vme_lwi = vme_in.sst_mode & vme_in.last_word_invalid;
   assign vme_exc = vme_in.master_active &
                    (vme_in.error_end | vme_slv_2evme | vme_lwi);

   // clear strobes; the clear bit itself is never stored
   assign vme_clr = bus_req.wr &&
                    bus_req.addr == capture_pkg::OFS_VME_ATTR &&
                    bus_req.wdata[capture_pkg::BIT_CLEAR];
   assign pcix_clr = bus_req.wr &&
                     bus_req.addr == capture_pkg::OFS_PCIX_CAUSE &&
                     bus_req.wdata[capture_pkg::BIT_CLEAR];

   // a clear in the same cycle as an event frees the slot for it
   assign vme_fire = vme_exc & (~st_reg.vme_valid | vme_clr);
   assign vme_ovf_evt = vme_exc & ~vme_fire;
   assign pcix_fire = pcix_in.error & (~st_reg.pcix_valid | pcix_clr);
   assign pcix_ovf_evt = pcix_in.error & ~pcix_fire;

   assign wr_irq_status = bus_req.wr &&
                          bus_req.addr == capture_pkg::OFS_IRQ_STATUS;
   assign wr_irq_mask = bus_req.wr &&
                        bus_req.addr == capture_pkg::OFS_IRQ_MASK;

   always_comb begin
      irq_events = '0;
      irq_events[capture_pkg::IRQ_VME_CAP] = vme_fire;
      irq_events[capture_pkg::IRQ_VME_OVF] = vme_ovf_evt;
      irq_events[capture_pkg::IRQ_PCIX_CAP] = pcix_fire;
      irq_events[capture_pkg::IRQ_PCIX_OVF] = pcix_ovf_evt;
   end

   always_comb begin
      st_next = st_reg;
      // vme side
      if (vme_clr) begin
         st_next.vme_valid = 1'b0;
         st_next.vme_ovf = 1'b0;
      end
      if (vme_fire) begin
         st_next.vme_addr_hi = vme_in.addr[63:32];
         st_next.vme_addr_lo = vme_in.addr[31:1];
         st_next.vme_attr.odd_beat_termination = vme_lwi |
            (vme_in.odd_beat & ~vme_in.sst_mode &
             (vme_slv_2evme | vme_in.error_end));
         st_next.vme_attr.two_edge_slave_stop = vme_in.slave_stop;
         st_next.vme_attr.bus_error = vme_in.error_end;
         st_next.vme_attr.lword = vme_in.lword;
         st_next.vme_attr.write = vme_in.write;
         st_next.vme_attr.iack = vme_in.iack;
         st_next.vme_attr.ds1 = vme_in.ds1;
         st_next.vme_attr.ds0 = vme_in.ds0;
         st_next.vme_attr.am = vme_in.am;
         st_next.vme_attr.xam = vme_in.xam;
         st_next.vme_valid = 1'b1;
      end else if (vme_ovf_evt) begin
         st_next.vme_ovf = 1'b1;
      end
      // pcix side
      if (pcix_clr) begin
         st_next.pcix_addr_hi = '0;
         st_next.pcix_addr_lo = '0;
         st_next.pcix_cause = '0;
         st_next.pcix_valid = 1'b0;
         st_next.pcix_ovf = 1'b0;
      end
      if (pcix_fire) begin
         st_next.pcix_addr_hi = pcix_in.addr[63:32];
         st_next.pcix_addr_lo = pcix_in.addr[31:0];
         st_next.pcix_attr_phase = pcix_in.attr_phase;
         st_next.pcix_split = pcix_in.split_msg;
         st_next.pcix_cause = pcix_in.cause;
         st_next.pcix_valid = 1'b1;
      end else if (pcix_ovf_evt) begin
         st_next.pcix_ovf = 1'b1;
      end
      // read port: data stand for one cycle only, unmapped reads zero
      st_next.rd_data = capture_pkg::RST_WORD;
      if (bus_req.rd) begin
         case (bus_req.addr)
            capture_pkg::OFS_VME_ADDR_HI: begin
               st_next.rd_data = st_reg.vme_addr_hi;
            end
            capture_pkg::OFS_VME_ADDR_LO: begin
               st_next.rd_data = {st_reg.vme_addr_lo, 1'b0};
            end
            capture_pkg::OFS_VME_ATTR: begin
               st_next.rd_data[capture_pkg::BIT_VALID] = st_reg.vme_valid;
               st_next.rd_data[capture_pkg::BIT_OVF] = st_reg.vme_ovf;
               st_next.rd_data[capture_pkg::VME_ATTR_W-1:0] =
                  st_reg.vme_attr;
            end
            capture_pkg::OFS_PCIX_ADDR_HI: begin
               st_next.rd_data = st_reg.pcix_addr_hi;
            end
            capture_pkg::OFS_PCIX_ADDR_LO: begin
               st_next.rd_data = st_reg.pcix_addr_lo;
            end
            capture_pkg::OFS_PCIX_ATTR_PHASE: begin
               st_next.rd_data = st_reg.pcix_attr_phase;
            end
            capture_pkg::OFS_PCIX_SPLIT_MSG: begin
               st_next.rd_data = st_reg.pcix_split;
            end
            capture_pkg::OFS_PCIX_CAUSE: begin
               st_next.rd_data[capture_pkg::BIT_VALID] = st_reg.pcix_valid;
               st_next.rd_data[capture_pkg::BIT_OVF] = st_reg.pcix_ovf;
               st_next.rd_data[capture_pkg::PCIX_CAUSE_W-1:0] =
                  st_reg.pcix_cause;
            end
            capture_pkg::OFS_IRQ_STATUS: begin
               st_next.rd_data[capture_pkg::IRQ_W-1:0] = irq_status;
            end
            capture_pkg::OFS_IRQ_MASK: begin
               st_next.rd_data[capture_pkg::IRQ_W-1:0] = irq_mask;
            end
            default: begin
               st_next.rd_data = capture_pkg::RST_WORD;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= '0;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   assign rd_data_reg = st_reg.rd_data;

   irq_status_unit u_irq (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .ce(ce),
      .event_set(irq_events),
      .wr_status(wr_irq_status),
      .wr_mask(wr_irq_mask),
      .wdata(bus_req.wdata[capture_pkg::IRQ_W-1:0]),
      .status_reg(irq_status),
      .mask_reg(irq_mask),
      .irq_reg(irq_reg)
   );

   // checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!arst_n);

   logic wr_capture_reg;
   assign wr_capture_reg = bus_req.wr &&
      (bus_req.addr == capture_pkg::OFS_VME_ADDR_HI ||
       bus_req.addr == capture_pkg::OFS_PCIX_ADDR_LO);

   chk_vme_addr_capture: assert property (
      ce && vme_fire |=> st_reg.vme_addr_hi == $past(vme_in.addr[63:32])
         && st_reg.vme_valid)
      else $error("vme upper address not captured");

   chk_vme_addr_low: assert property (
      ce && vme_fire |=>
         st_reg.vme_addr_lo == $past(vme_in.addr[31:1]))
      else $error("vme lower address not captured");

   chk_vme_set_status: assert property (
      ce && vme_in.master_active && vme_in.error_end &&
      !st_reg.vme_valid |=> st_reg.vme_valid)
      else $error("vme status not set on error end");

   chk_vme_hold_overflow: assert property (
      ce && vme_exc && st_reg.vme_valid && !vme_clr |=>
         $stable(st_reg.vme_addr_hi) && $stable(st_reg.vme_attr) &&
         st_reg.vme_ovf && st_reg.vme_valid)
      else $error("vme capture changed while status set");

   chk_vme_clear_reads: assert property (
      ce && vme_clr && !vme_exc |=> !st_reg.vme_valid && !st_reg.vme_ovf)
      else $error("vme clear did not drop status");

   chk_vme_clear_zero: assert property (
      ce && bus_req.rd && bus_req.addr == capture_pkg::OFS_VME_ATTR |=>
         !rd_data_reg[capture_pkg::BIT_CLEAR] &&
         rd_data_reg[capture_pkg::BIT_VALID] == $past(st_reg.vme_valid))
      else $error("vme attribute read wrong");

   chk_vme_odd_flag: assert property (
      ce && vme_fire && vme_lwi |=>
         st_reg.vme_attr.odd_beat_termination)
      else $error("odd termination flag missing");

   chk_vme_cause_flags: assert property (
      ce && vme_fire |=>
         st_reg.vme_attr.bus_error == $past(vme_in.error_end) &&
         st_reg.vme_attr.two_edge_slave_stop == $past(vme_in.slave_stop)
         && st_reg.vme_attr.am == $past(vme_in.am))
      else $error("vme cause flags wrong");

   chk_pcix_capture: assert property (
      ce && pcix_fire |=> st_reg.pcix_addr_lo == $past(pcix_in.addr[31:0])
         && st_reg.pcix_split == $past(pcix_in.split_msg)
         && st_reg.pcix_cause == $past(pcix_in.cause) && st_reg.pcix_valid)
      else $error("pcix capture wrong");

   chk_pcix_overflow: assert property (
      ce && pcix_in.error && st_reg.pcix_valid && !pcix_clr |=>
         st_reg.pcix_ovf && $stable(st_reg.pcix_addr_hi) &&
         $stable(st_reg.pcix_attr_phase))
      else $error("pcix capture changed while status set");

   chk_pcix_clear_zero: assert property (
      ce && pcix_clr && !pcix_in.error |=>
         st_reg.pcix_addr_hi == '0 && st_reg.pcix_addr_lo == '0 &&
         st_reg.pcix_cause == '0 && !st_reg.pcix_valid)
      else $error("pcix clear incomplete");

   chk_write_ignored: assert property (
      ce && wr_capture_reg && !vme_exc && !pcix_in.error |=>
         $stable(st_reg.vme_addr_hi) && $stable(st_reg.pcix_addr_lo))
      else $error("capture register changed by write");

   chk_irq_level: assert property (
      ce && vme_fire && irq_mask[capture_pkg::IRQ_VME_CAP] &&
      !wr_irq_mask |=> irq_reg)
      else $error("interrupt not raised");

   chk_vme_slave_flag: assert property (
      ce && vme_fire && vme_slv_2evme |=>
         st_reg.vme_attr.two_edge_slave_stop)
      else $error("slave terminated flag missing");

   chk_vme_odd_beat: assert property (
      ce && vme_fire && !vme_in.sst_mode && vme_in.odd_beat |=>
         st_reg.vme_attr.odd_beat_termination)
      else $error("odd beat termination flag missing");

   chk_vme_strobes: assert property (
      ce && vme_fire |=>
         st_reg.vme_attr.lword == $past(vme_in.lword) &&
         st_reg.vme_attr.write == $past(vme_in.write) &&
         st_reg.vme_attr.iack == $past(vme_in.iack) &&
         st_reg.vme_attr.ds1 == $past(vme_in.ds1) &&
         st_reg.vme_attr.ds0 == $past(vme_in.ds0))
      else $error("vme bus signals not captured");

   chk_vme_modifiers: assert property (
      ce && vme_fire |=> st_reg.vme_attr.am == $past(vme_in.am) &&
         st_reg.vme_attr.xam == $past(vme_in.xam))
      else $error("vme address modifiers not captured");

   chk_vme_status_hold: assert property (
      ce && st_reg.vme_valid && !vme_clr |=> st_reg.vme_valid)
      else $error("vme status dropped without clear");

   chk_vme_low_read: assert property (
      ce && bus_req.rd && bus_req.addr == capture_pkg::OFS_VME_ADDR_LO |=>
         rd_data_reg == {$past(st_reg.vme_addr_lo), 1'b0})
      else $error("vme lower address read wrong");

   chk_pcix_addr_high: assert property (
      ce && pcix_fire |=> st_reg.pcix_addr_hi == $past(pcix_in.addr[63:32]))
      else $error("pcix upper address not captured");

   chk_pcix_attr_phase: assert property (
      ce && pcix_fire |=>
         st_reg.pcix_attr_phase == $past(pcix_in.attr_phase))
      else $error("pcix attribute phase not captured");

   chk_pcix_split_msg: assert property (
      ce && pcix_fire |=> st_reg.pcix_split == $past(pcix_in.split_msg))
      else $error("pcix split message not captured");

   chk_pcix_status_set: assert property (
      ce && pcix_in.error && !st_reg.pcix_valid |=> st_reg.pcix_valid)
      else $error("pcix status not set on error");

   chk_pcix_status_hold: assert property (
      ce && st_reg.pcix_valid && !pcix_clr |=> st_reg.pcix_valid)
      else $error("pcix status dropped without clear");

   chk_pcix_cause_read: assert property (
      ce && bus_req.rd && bus_req.addr == capture_pkg::OFS_PCIX_CAUSE |=>
         rd_data_reg[capture_pkg::PCIX_CAUSE_W-1:0] ==
            $past(st_reg.pcix_cause) &&
         !rd_data_reg[capture_pkg::BIT_CLEAR])
      else $error("pcix cause read wrong");

   chk_read_idle: assert property (
      ce && !bus_req.rd |=> rd_data_reg == capture_pkg::RST_WORD)
      else $error("read data stood beyond its cycle");

   cov_vme_capture: cover property (ce && vme_fire ##1 ce && vme_clr);
   cov_vme_overflow: cover property (ce && vme_ovf_evt);
   cov_pcix_capture: cover property (ce && pcix_fire ##[1:4] pcix_clr);
   cov_clear_with_event: cover property (ce && vme_clr && vme_exc);

endmodule : bus_exception_capture

/* tb/far_side_model.sv */
// far-side agents: vme slave ending a master transfer, pcix bus error source
// assumes the bench changes fire, kind and seed just after ref_clk edges
`timescale 1ns/1ps
module far_side_model (
   input wire logic fire_vme,
   input wire logic [1:0] vme_kind,
   input wire logic fire_pcix,
   input wire logic [31:0] seed,
   output capture_pkg::vme_event_t vme_in,
   output capture_pkg::pcix_event_t pcix_in
);
   // kind 0 error end, 1 2evme slave stop, 2 2esst last word invalid
   // idle: not master, but ending lines noisy and bus values moving
   always_comb begin
      vme_in.master_active = fire_vme;
      vme_in.error_end = !fire_vme || vme_kind == 2'h0;
      vme_in.slave_stop = !fire_vme || vme_kind == 2'h1;
      vme_in.sst_mode = fire_vme && vme_kind == 2'h2;
      vme_in.last_word_invalid = !fire_vme || vme_kind == 2'h2;
      vme_in.odd_beat = seed[0];
      vme_in.addr = {seed ^ 32'h5a5a_5a5a, seed};
      {vme_in.lword, vme_in.write, vme_in.iack, vme_in.ds1, vme_in.ds0,
         vme_in.am, vme_in.xam} = seed[18:0];
      pcix_in.error = fire_pcix;
      pcix_in.addr = {~seed, seed};
      pcix_in.attr_phase = seed ^ 32'h0f0f_0f0f;
      pcix_in.split_msg = {seed[15:0], seed[31:16]};
      pcix_in.cause = seed[17:0];
   end
endmodule : far_side_model

/* tb/testbench.sv */
// self-checking bench for the bus exception capture block
// assumes the far side model and the design package are compiled first
`timescale 1ns/1ps
module testbench;
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   capture_pkg::reg_req_t req = '0;
   capture_pkg::vme_event_t vme_in;
   capture_pkg::pcix_event_t pcix_in;
   logic fire_vme = 1'b0;
   logic fire_pcix = 1'b0;
   logic [1:0] vme_kind = 2'h0;
   logic [31:0] seed = 32'h0;
   logic [31:0] rd_data_reg;
   logic irq_reg;
   logic ce = 1'b1;
   logic [31:0] s;
   logic [31:0] e;
   int miscompares = 0;
   int n_checks = 0;
   int cycles = 0;

   always #50 ref_clk = ~ref_clk;

   bus_exception_capture bus_exception_capture_i (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .ce(ce),
      .bus_req(req),
      .vme_in(vme_in),
      .pcix_in(pcix_in),
      .rd_data_reg(rd_data_reg),
      .irq_reg(irq_reg)
   );

   far_side_model far_side_model_i (
      .fire_vme(fire_vme),
      .vme_kind(vme_kind),
      .fire_pcix(fire_pcix),
      .seed(seed),
      .vme_in(vme_in),
      .pcix_in(pcix_in)
   );

   task automatic results;
      if (miscompares == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : results

   task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      req.wr <= 1'b1;
      req.addr <= a;
      req.wdata <= d;
      @(posedge ref_clk);
      req.wr <= 1'b0;
   endtask : wr

   // read data is looked at in the one cycle where it stands
   task automatic rd(input logic [11:0] a, input logic [31:0] exp,
      input string what);
      @(posedge ref_clk);
      req.rd <= 1'b1;
      req.addr <= a;
      @(posedge ref_clk);
      req.rd <= 1'b0;
      #1;
      chk(what, exp, rd_data_reg);
   endtask : rd

   // one-cycle event; the seed is inverted afterwards so idle values move
   task automatic fire(input logic v, input logic [1:0] k,
      input logic [31:0] sd);
      @(posedge ref_clk);
      fire_vme <= v;
      fire_pcix <= !v;
      vme_kind <= k;
      seed <= sd;
      @(posedge ref_clk);
      fire_vme <= 1'b0;
      fire_pcix <= 1'b0;
      seed <= ~sd;
   endtask : fire

   // expected vme attribute bits 21:0 for an event kind and seed
   function automatic logic [21:0] vexp(input logic [1:0] k,
      input logic [31:0] sd);
      vexp = {k == 2'h2 || sd[0], k == 2'h1, k == 2'h0, sd[18:0]};
   endfunction : vexp

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         results();
      end
   end

   initial begin
      repeat (5) @(posedge ref_clk);
      arst_n <= 1'b1;
      chk("irq after reset", 32'h0, {31'h0, irq_reg});
      for (int i = 0; i < 8; i++) begin
         e = {20'h0, 12'h260 + 12'(4 * i) + (i > 2 ? 12'h4 : 12'h0)};
         rd(e[11:0], 32'h0, "reset value");
         wr(e[11:0], 32'hdfff_ffff);
         rd(e[11:0], 32'h0, "after write");
      end
      @(posedge ref_clk);
      #1;
      chk("read data after its cycle", 32'h0, rd_data_reg);
      wr(12'h2a0, 32'hffff_ffff);
      rd(12'h2a0, 32'h0, "unmapped");
      wr(12'h294, 32'h0000_000f);
      for (int k = 0; k < 3; k++) begin
         s = 32'h89ab_cdef + 32'h1111_1111 * 32'(k);
         fire(1'b1, 2'(k), s);
         #1;
         chk("irq on capture", 32'h1, {31'h0, irq_reg});
         fire(1'b1, 2'h0, ~s);
         rd(12'h260, s ^ 32'h5a5a_5a5a, "vme addr high");
         rd(12'h264, {s[31:1], 1'b0}, "vme addr low");
         e = {2'b11, 8'h0, vexp(2'(k), s)};
         rd(12'h268, e, "vme attributes");
         rd(12'h290, 32'h3, "irq status");
         wr(12'h268, 32'hdfff_ffff);
         rd(12'h268, e, "vme clear written zero");
         wr(12'h268, 32'h2000_0000);
         rd(12'h268, {10'h0, vexp(2'(k), s)}, "vme cleared");
         wr(12'h290, 32'h3);
         #1;
         chk("irq after status clear", 32'h0, {31'h0, irq_reg});
      end
      // reset in mid run drops captured contents
      @(posedge ref_clk);
      arst_n <= 1'b0;
      @(posedge ref_clk);
      arst_n <= 1'b1;
      rd(12'h268, 32'h0, "attributes after reset");
      rd(12'h260, 32'h0, "address after reset");
      wr(12'h294, 32'h0);
      s = 32'h2468_ace1;
      fire(1'b0, 2'h0, s);
      #1;
      chk("irq masked", 32'h0, {31'h0, irq_reg});
      fire(1'b0, 2'h0, 32'h0);
      rd(12'h270, ~s, "pcix addr high");
      rd(12'h274, s, "pcix addr low");
      rd(12'h278, s ^ 32'h0f0f_0f0f, "pcix attr phase");
      rd(12'h27c, {s[15:0], s[31:16]}, "pcix split");
      rd(12'h280, {2'b11, 12'h0, s[17:0]}, "pcix cause");
      rd(12'h290, 32'hc, "irq status pcix");
      wr(12'h294, 32'h0000_000c);
      rd(12'h294, 32'hc, "irq mask");
      chk("irq unmasked", 32'h1, {31'h0, irq_reg});
      wr(12'h280, 32'h2000_0000);
      rd(12'h270, 32'h0, "pcix high cleared");
      rd(12'h274, 32'h0, "pcix low cleared");
      rd(12'h280, 32'h0, "pcix cause cleared");
      rd(12'h278, s ^ 32'h0f0f_0f0f, "attr phase kept");
      rd(12'h27c, {s[15:0], s[31:16]}, "split kept");
      // an exception while the clock enable is low must not be taken
      @(posedge ref_clk);
      ce <= 1'b0;
      fire(1'b1, 2'h0, 32'h1357_9bdf);
      ce <= 1'b1;
      rd(12'h290, 32'hc, "irq status held by ce");
      rd(12'h268, 32'h0, "vme attributes held by ce");
      results();
   end
endmodule : testbench
